// ==== hdl/phy_buffer_link_port.sv ====
// Notes on behaviour
// - both streams carry 64-bit header and payload words
// - beat moves on valid and ready together
// - packet-end marks final beat both directions
// - receive keep full except final beat
// - keep bit 7 is top byte
// - discontinue on final tx beat discards packet
// - first receive beat user bit1 carries priority flag
// - host setting output from control state
// - long symbol mode gives 6-bit indices
// - next index advances per sent (not discarded) packet, rewinds back
// - last received acknowledge index output
// - last received partner buffer status output
`timescale 1ns/1ps
`default_nettype none
module phy_buffer_link_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tx_valid_in,
  input wire link_port_pkg::beat_t tx_beat_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output link_port_pkg::beat_t rx_beat_out,
  input wire logic rx_ready_in,
  input wire logic host_cfg_in,
  input wire logic request_enable_cfg_in,
  input wire logic long_symbol_cfg_in,
  input wire logic ack_event_in,
  input wire logic [link_port_pkg::IDX_W-1:0] ack_index_in,
  input wire logic status_event_in,
  input wire logic [link_port_pkg::STAT_W-1:0] partner_status_in,
  input wire logic rewind_in,
  input wire logic [link_port_pkg::IDX_W-1:0] rewind_index_in,
  input wire logic [link_port_pkg::STAT_W-1:0] buffer_status_in,
  input wire logic tx_paced_in,
  output logic host_out,
  output logic request_enable_out,
  output logic long_symbol_mode_out,
  output logic rewind_out,
  output logic [link_port_pkg::IDX_W-1:0] next_send_index_out,
  output logic [link_port_pkg::IDX_W-1:0] last_ack_index_out,
  output logic [link_port_pkg::STAT_W-1:0] partner_status_out,
  output logic [link_port_pkg::STAT_W-1:0] own_status_out,
  output logic tx_paced_out,
  output logic tx_sent_out,
  output logic tx_discarded_out,
  output logic [link_port_pkg::KEEP_W-1:0] tx_last_keep_out
);
  import link_port_pkg::*;

  function automatic logic [IDX_W-1:0] index_wrap(input logic [IDX_W-1:0] v,
                                                  input logic long_mode);
    index_wrap = long_mode ? v : (v & SHORT_IDX_MASK);
  endfunction : index_wrap

  tx_state_t tx_state_reg;
  logic tx_take;
  logic rx_take;
  logic rx_slot_free;

  // transmit side is ready from the cycle after reset releases; the engine absorbs one word per cycle
  assign tx_take = tx_valid_in & tx_ready_out;
  assign rx_take = rx_valid_out & rx_ready_in;
  assign rx_slot_free = ~rx_valid_out | rx_ready_in;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= 1'b1;
    end
  end

  // packet tracking: first beat, final beat, discontinue
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_state_reg <= TX_IDLE;
      tx_sent_out <= 1'b0;
      tx_discarded_out <= 1'b0;
      tx_last_keep_out <= KEEP_FULL;
    end else begin
      tx_sent_out <= 1'b0;
      tx_discarded_out <= 1'b0;
      if (tx_take) begin
        case (tx_state_reg)
          TX_IDLE, TX_BODY: begin
            if (tx_beat_in.last) begin
              tx_state_reg <= TX_IDLE;
              tx_last_keep_out <= tx_beat_in.keep;
              if (tx_beat_in.user[USER_DISCONTINUE_BIT]) begin
                tx_discarded_out <= 1'b1;
              end else begin
                tx_sent_out <= 1'b1;
              end
            end else begin
              tx_state_reg <= TX_BODY;
            end
          end
          TX_DROP: begin
            if (tx_beat_in.last) begin
              tx_state_reg <= TX_IDLE;
            end
          end
          default: begin
            tx_state_reg <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // receive stream: one register stage toward the buffer
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_valid_out <= 1'b0;
      rx_beat_out <= '0;
    end else if (rx_slot_free) begin
      rx_valid_out <= tx_take;
      if (tx_take) begin
        rx_beat_out.data <= tx_beat_in.data;
        rx_beat_out.last <= tx_beat_in.last;
        rx_beat_out.keep <= tx_beat_in.last ? tx_beat_in.keep : KEEP_FULL;
        rx_beat_out.user <= '0;
        if (tx_state_reg == TX_IDLE) begin
          rx_beat_out.user[USER_PRIORITY_BIT] <= tx_beat_in.user[USER_PRIORITY_BIT];
        end
        if (tx_beat_in.last) begin
          rx_beat_out.user[USER_DISCONTINUE_BIT] <= tx_beat_in.user[USER_DISCONTINUE_BIT];
        end
      end
    end else if (rx_take) begin
      rx_valid_out <= 1'b0;
    end
  end

  // configuration mirrors
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      host_out <= 1'b0;
      request_enable_out <= 1'b0;
      long_symbol_mode_out <= 1'b0;
      tx_paced_out <= 1'b0;
    end else begin
      host_out <= host_cfg_in;
      request_enable_out <= request_enable_cfg_in;
      long_symbol_mode_out <= long_symbol_cfg_in;
      tx_paced_out <= tx_paced_in;
    end
  end

  // acknowledge indices
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      next_send_index_out <= IDX_RESET;
      last_ack_index_out <= IDX_RESET;
      rewind_out <= 1'b0;
    end else begin
      rewind_out <= rewind_in;
      if (rewind_in) begin
        next_send_index_out <= index_wrap(rewind_index_in, long_symbol_cfg_in);
      end else if (tx_sent_out) begin
        next_send_index_out <= index_wrap(next_send_index_out + IDX_W'(1),
                                          long_symbol_cfg_in);
      end
      if (ack_event_in) begin
        last_ack_index_out <= index_wrap(ack_index_in, long_symbol_cfg_in);
      end
    end
  end

  // buffer status in both directions
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      partner_status_out <= STAT_RESET;
      own_status_out <= STAT_RESET;
    end else begin
      if (status_event_in) begin
        partner_status_out <= partner_status_in;
      end
      // clamp guards against flow-control patterns if the buffer misbehaves
      own_status_out <= (buffer_status_in > STAT_W'(30)) ? STAT_W'(30)
                                                         : buffer_status_in;
    end
  end
endmodule : phy_buffer_link_port
`default_nettype wire

// ==== pkg/link_port_pkg.sv ====
`default_nettype none
package link_port_pkg;
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam int USER_W = 8;
  localparam int IDX_W = 6;
  localparam int STAT_W = 6;
  localparam logic [KEEP_W-1:0] KEEP_FULL = 8'hFF;
  localparam int USER_DISCONTINUE_BIT = 0;
  localparam int USER_PRIORITY_BIT = 1;
  localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;
  localparam logic [IDX_W-1:0] SHORT_IDX_MASK = 6'h1F;
  localparam logic [STAT_W-1:0] STAT_RESET = 6'h00;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
    logic [USER_W-1:0] user;
  } beat_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BODY = 2'b01,
    TX_DROP = 2'b10
  } tx_state_t;
endpackage : link_port_pkg
`default_nettype wire

// ==== tb/buffer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module buffer_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic stall_in,
  input wire logic rx_valid_in,
  input wire link_port_pkg::beat_t rx_beat_in,
  output logic rx_ready_out,
  output int kept_out
);
  import link_port_pkg::*;
  assign rx_ready_out = !stall_in;
  // a discontinued packet never counts as stored
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      kept_out <= 0;
    end else if (rx_valid_in && rx_ready_out && rx_beat_in.last && !rx_beat_in.user[0]) begin
      kept_out <= kept_out + 1;
    end
  end
endmodule : buffer_model
`default_nettype wire

// ==== tb/phy_buffer_link_port_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module phy_buffer_link_port_chk (
  input wire logic clk_in, rst_b_in, tx_valid_in, tx_ready_out, rx_valid_out, rx_ready_in,
  input wire logic host_cfg_in, host_out, rewind_in, rewind_out, tx_sent_out, tx_discarded_out,
  input wire logic long_symbol_mode_out,
  input wire link_port_pkg::beat_t tx_beat_in, rx_beat_out,
  input wire logic [5:0] rewind_index_in, next_send_index_out, own_status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence take_last;
    tx_valid_in && tx_ready_out && tx_beat_in.last;
  endsequence
  a_rx_keep: assert property (rx_valid_out && !rx_beat_out.last
    |-> rx_beat_out.keep == 8'hFF) else $error("rx keep not full");
  a_rx_hold: assert property (rx_valid_out && !rx_ready_in
    |=> rx_valid_out && $stable(rx_beat_out)) else $error("rx beat dropped");
  a_sent_pulse: assert property (take_last ##0 !tx_beat_in.user[0]
    |=> tx_sent_out) else $error("no sent pulse");
  a_discard_pulse: assert property (take_last ##0 tx_beat_in.user[0]
    |=> tx_discarded_out && !tx_sent_out) else $error("no discard");
  // short mode wraps at 31, so that step is left out here
  a_index_step: assert property (tx_sent_out && !rewind_in && next_send_index_out[4:0] != 5'h1F
    |=> next_send_index_out == $past(next_send_index_out) + 6'h01)
    else $error("index step");
  a_rewind_load: assert property (rewind_in && long_symbol_mode_out
    |=> rewind_out && next_send_index_out == $past(rewind_index_in)) else $error("rewind");
  a_status_cap: assert property (own_status_out <= 6'h1E) else $error("status");
  a_host_mirror: assert property ($past(rst_b_in) |-> host_out == $past(host_cfg_in))
    else $error("host mirror");
endmodule : phy_buffer_link_port_chk
bind phy_buffer_link_port phy_buffer_link_port_chk chk_u (.*);
`default_nettype wire

// ==== tb/tb_phy_buffer_link_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_phy_buffer_link_port;
  import link_port_pkg::*;
  logic clk_in = 1'b0, rst_b_in = 1'b0, tx_valid_in = 1'b0, stall = 1'b0, rewind_in = 1'b0;
  logic host_cfg_in = 1'b0, request_enable_cfg_in = 1'b0, long_symbol_cfg_in = 1'b1;
  logic ack_event_in = 1'b0, status_event_in = 1'b0, tx_paced_in = 1'b0;
  logic [5:0] ack_index_in = 6'h00, partner_status_in = 6'h00, rewind_index_in = 6'h00;
  logic [5:0] buffer_status_in = 6'h00;
  beat_t tx_beat_in = '0;
  beat_t rx_beat_out;
  logic tx_ready_out, rx_valid_out, rx_ready_in, host_out, request_enable_out, tx_paced_out;
  logic long_symbol_mode_out, rewind_out, tx_sent_out, tx_discarded_out;
  logic [5:0] next_send_index_out, last_ack_index_out, partner_status_out, own_status_out;
  logic [7:0] tx_last_keep_out;
  logic [5:0] sv [4] = '{6'h05, 6'h1E, 6'h1F, 6'h3F};
  int kept, mismatches = 0, checks_done = 0;
  phy_buffer_link_port dut_u (.*);
  buffer_model model_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .stall_in(stall),
    .rx_valid_in(rx_valid_out), .rx_beat_in(rx_beat_out), .rx_ready_out(rx_ready_in),
    .kept_out(kept));
  always #20 clk_in = ~clk_in;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // valid drops only after a final beat, so packets never run into each other here
  task automatic put(input logic [7:0] keep, input logic last, input logic [7:0] user);
    tx_valid_in <= 1'b1;
    tx_beat_in <= '{data: {8{keep}}, keep: keep, last: last, user: user};
    @(posedge clk_in);
    while (tx_ready_out !== 1'b1) @(posedge clk_in);
    if (last) tx_valid_in <= 1'b0;
  endtask : put
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk_in);
    #1 cmp({7'h0, tx_ready_out}, 8'h00);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    put(8'hFF, 1'b0, 8'h02);
    put(8'hFF, 1'b0, 8'h00);
    put(8'h07, 1'b1, 8'h00);
    #1 cmp({7'h0, tx_sent_out}, 8'h01);
    cmp(tx_last_keep_out, 8'h07);
    @(posedge clk_in);
    #1 cmp({2'h0, next_send_index_out}, 8'h01);
    @(posedge clk_in);
    put(8'h01, 1'b1, 8'h01);
    #1 cmp({6'h0, tx_discarded_out, tx_sent_out}, 8'h02);
    @(posedge clk_in);
    #1 cmp({2'h0, next_send_index_out}, 8'h01);
    $display("test stream done");
    @(posedge clk_in);
    stall <= 1'b1;
    put(8'h0F, 1'b1, 8'h00);
    repeat (3) @(posedge clk_in);
    #1 cmp(rx_beat_out.keep, 8'h0F);
    cmp(rx_beat_out.data[63:56], 8'h0F);
    cmp({6'h0, rx_valid_out, rx_beat_out.last}, 8'h03);
    stall <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 cmp(kept[7:0], 8'h02);
    @(posedge clk_in);
    rewind_in <= 1'b1;
    rewind_index_in <= 6'h2A;
    @(posedge clk_in);
    rewind_in <= 1'b0;
    #1 cmp({1'b0, rewind_out, next_send_index_out}, 8'h6A);
    $display("test stall and rewind done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_in);
      long_symbol_cfg_in <= m[0];
      repeat (2) @(posedge clk_in);
      ack_event_in <= 1'b1;
      ack_index_in <= 6'h3B;
      @(posedge clk_in);
      ack_event_in <= 1'b0;
      #1 cmp({2'h0, last_ack_index_out}, m[0] ? 8'h3B : 8'h1B);
    end
    $display("test ack index done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      buffer_status_in <= sv[i];
      status_event_in <= 1'b1;
      partner_status_in <= sv[i];
      host_cfg_in <= i[0];
      request_enable_cfg_in <= i[0];
      tx_paced_in <= i[0];
      repeat (2) @(posedge clk_in);
      #1 cmp({2'h0, own_status_out}, (sv[i] > 6'h1E) ? 8'h1E : {2'h0, sv[i]});
      cmp({2'h0, partner_status_out}, {2'h0, sv[i]});
      cmp({5'h0, host_out, request_enable_out, tx_paced_out}, {5'h0, {3{i[0]}}});
    end
    $display("test status and settings done");
    summarize();
  end
  initial begin
    repeat (1000) @(posedge clk_in);
    mismatches++;
    summarize();
  end
endmodule : tb_phy_buffer_link_port
`default_nettype wire
